// file: sfb_pkg.sv
// Shared constants and types for the nonvolatile burst front end
package sfb_pkg;
    ////////////////////////////////////////////////////////////////////////
    // Widths
    localparam int ADDR_W     = 12;
    localparam int ROW_W      = 12;
    localparam int COL_W      = 8;
    localparam int BANK_W     = 2;
    localparam int BANKS      = 4;
    localparam int DATA_W     = 32;
    localparam int MODE_W     = 12;
    localparam int LEN_W      = 2;
    localparam int FIFO_DEPTH = 16;
    localparam int WORD_W     = BANK_W + ROW_W + COL_W + DATA_W;
    ////////////////////////////////////////////////////////////////////////
    // Organisation masks
    localparam logic [ROW_W-1:0]  ROW_MASK_NARROW  = 12'hfff;
    localparam logic [ROW_W-1:0]  ROW_MASK_WIDE    = 12'h7ff;
    localparam logic [DATA_W-1:0] DATA_MASK_NARROW = 32'h0000ffff;
    localparam logic [DATA_W-1:0] DATA_MASK_WIDE   = 32'hffffffff;
    localparam logic [COL_W-1:0]  COL_MASK_FULL    = 8'hff;
    ////////////////////////////////////////////////////////////////////////
    // Operating configuration fields
    localparam int BL_LSB = 0;
    localparam int BL_MSB = 2;
    localparam int BT_BIT = 3;
    localparam int CL_LSB = 4;
    localparam int CL_MSB = 6;
    localparam int OM_LSB = 7;
    localparam int OM_MSB = 8;
    localparam int WB_BIT = 9;
    localparam logic [2:0]        BL_8          = 3'h3;
    localparam logic [2:0]        BL_FULL       = 3'h7;
    localparam logic [2:0]        CL_1          = 3'h1;
    localparam logic [2:0]        CL_2          = 3'h2;
    localparam logic [2:0]        CL_3          = 3'h3;
    localparam logic [1:0]        OM_NORMAL     = 2'h0;
    localparam logic [LEN_W-1:0]  LEN_1         = 2'h0;
    localparam logic [LEN_W-1:0]  LEN_8         = 2'h3;
    localparam logic [MODE_W-1:0] NV_MODE_RESET = 12'h020;
    ////////////////////////////////////////////////////////////////////////
    // Command codes, {row strobe, column strobe, write enable}
    localparam logic [2:0] CMD_NOP       = 3'h7;
    localparam logic [2:0] CMD_ACTIVE    = 3'h3;
    localparam logic [2:0] CMD_READ      = 3'h5;
    localparam logic [2:0] CMD_WRITE     = 3'h4;
    localparam logic [2:0] CMD_BST       = 3'h6;
    localparam logic [2:0] CMD_ACT_TERM  = 3'h2;
    localparam logic [2:0] CMD_LOAD_CMD  = 3'h1;
    localparam logic [2:0] CMD_LOAD_MODE = 3'h0;
    localparam logic [COL_W-1:0] CODE_INIT       = 8'h0b;
    localparam logic [COL_W-1:0] CODE_STORE_MODE = 8'h0d;
    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_MHZ         = 50;
    localparam int INIT_TIME_US    = 100;
    localparam int INIT_CYCLES_DEF = INIT_TIME_US * CLK_MHZ;
    localparam int INIT_W          = 13;
    typedef enum logic [1:0] {
        ST_POWER_DOWN = 2'h0,
        ST_INIT       = 2'h1,
        ST_STANDBY    = 2'h2
    } sfb_state_e;
endpackage

// file: sfb_fifo.sv
// Write data buffer with valid and ready on both sides
module sfb_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 16
) (
    input  wire logic         ref_clk,
    input  wire logic         rst_b,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic      [W-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    logic [W-1:0]  mem_reg [DEPTH];
    logic [PW-1:0] wr_ptr_reg;
    logic [PW-1:0] rd_ptr_reg;
    logic [PW:0]   count_reg;
    wire           push = in_valid && in_ready;
    wire           pop  = out_valid && out_ready;
    assign in_ready  = count_reg != (PW+1)'(DEPTH);
    assign out_valid = count_reg != '0;
    assign out_data  = mem_reg[rd_ptr_reg];
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_reg + PW'(push);
            rd_ptr_reg <= rd_ptr_reg + PW'(pop);
            count_reg  <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule

// file: sfb_burst_addr.sv
// Column sequencer for one burst with block wrap
module sfb_burst_addr
    import sfb_pkg::*;
(
    input  wire logic             ref_clk,
    input  wire logic             rst_b,
    input  wire logic             load,
    input  wire logic             stop,
    input  wire logic [COL_W-1:0] start_col,
    input  wire logic [LEN_W-1:0] len_log,
    input  wire logic             full_page,
    input  wire logic             interleave,
    output logic      [COL_W-1:0] col,
    output logic                  vld,
    output logic                  vld_next
);
    logic [COL_W-1:0] col_reg;
    logic [COL_W-1:0] cnt_reg;
    logic [COL_W-1:0] start_reg;
    logic [COL_W-1:0] mask_reg;
    logic             full_reg;
    logic             ilv_reg;
    logic             vld_reg;
    wire [COL_W-1:0] mask_in  = full_page ? COL_MASK_FULL : ~(COL_MASK_FULL << len_log);
    wire [COL_W-1:0] s        = load ? start_col : start_reg;
    wire [COL_W-1:0] m        = load ? mask_in : mask_reg;
    wire             i        = load ? interleave : ilv_reg;
    wire             last     = !full_reg && cnt_reg == mask_reg;
    wire [COL_W-1:0] cnt_next = load ? '0 : cnt_reg + COL_W'(1);
    // Block picked by high bits, start and order by low bits
    wire [COL_W-1:0] off      = i ? (s ^ cnt_next) : (s + cnt_next); // R24
    wire [COL_W-1:0] col_next = (s & ~m) | (off & m); // R19 R20 R21
    assign vld_next = load || (vld_reg && !stop && !last); // R17 R18
    assign col = col_reg;
    assign vld = vld_reg;
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            vld_reg   <= 1'b0;
            col_reg   <= '0;
            cnt_reg   <= '0;
            start_reg <= '0;
            mask_reg  <= '0;
            full_reg  <= 1'b0;
            ilv_reg   <= 1'b0;
        end else begin
            vld_reg <= vld_next;
            cnt_reg <= cnt_next;
            col_reg <= col_next;
            if (load) begin
                start_reg <= start_col;
                mask_reg  <= mask_in;
                full_reg  <= full_page;
                ilv_reg   <= interleave;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    start_col_a: // R19
        assert property (load |=> col_reg == $past(start_col))
        else $error("burst did not start at the given column");
    block_wrap_a: // R20
        assert property (vld_reg && $past(vld_reg) && !$past(load)
                         |-> ((col_reg ^ $past(col_reg)) & mask_reg) == (col_reg ^ $past(col_reg)))
        else $error("burst left its block");
    page_wrap_a: // R21
        assert property (vld_reg && full_reg && $past(vld_reg) && !$past(load)
                         |-> col_reg == $past(col_reg) + COL_W'(1))
        else $error("full page burst did not step or wrap in row");
endmodule

// file: sfb_ctrl.sv
// Command front end of a four-bank nonvolatile synchronous memory
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// (R1) Sample all inputs on rising clock only
// (R2) Four banks, narrow or wide row organisation
// (R3) Controller activates row before column read
// (R4) Activate takes bank bits and row address
// (R5) Read takes start column from A0-A7
// (R6) Non-read operations start by command sequence
// (R7) Pin rise starts init, done within 100us
// (R8) Init command starts same init, 100us
// (R9) Ready status bit shows init completion
// (R10) After init: standby, accept mode or commands
// (R11) Init copies stored mode into configuration
// (R12) Store command copies configuration to stored
// (R13) Configuration changes only by load-mode command; code also reloads it from stored at init start
// (R14) Field layout: length, type, latency, mode, write
// (R15) Controller loads configuration only when idle; lmr_go accepts it in standby with rows open or a burst running
// (R16) Lengths 1,2,4,8; full page sequential reads
// (R17) Length caps column locations per command
// (R18) Full page runs until burst terminate
// (R19) High column bits pick block, low start
// (R20) Burst wraps inside its block
// (R21) Full page wraps inside the row
// (R22) Controller avoids reserved configuration codes
// (R23) Drive after n+m-1, data at n+m
// (R24) Type bit picks sequential or interleaved
// (R25) Normal operation only with mode bits zero
// (R26) Write burst bit makes writes single
////////////////////////////////////////////////////////////////////////////////
module sfb_ctrl
    import sfb_pkg::*;
#(
    parameter int INIT_CYCLES = INIT_CYCLES_DEF
) (
    input  wire logic              ref_clk,
    input  wire logic              rst_b,
    input  wire logic              power_down_init_pin,
    input  wire logic              cs_b,
    input  wire logic              ras_b,
    input  wire logic              cas_b,
    input  wire logic              we_b,
    input  wire logic              bank_select_bit_low,
    input  wire logic              bank_select_bit_high,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic              wide_config,
    input  wire logic [DATA_W-1:0] dq_in,
    output logic      [DATA_W-1:0] dq_out,
    output logic                   dq_oe,
    output logic                   status_ready_bit,
    output logic                   array_rd_en,
    output logic      [BANK_W-1:0] array_bank,
    output logic      [ROW_W-1:0]  array_row,
    output logic      [COL_W-1:0]  array_col,
    input  wire logic [DATA_W-1:0] array_rd_data,
    output logic                   array_wr_valid,
    input  wire logic              array_wr_ready,
    output logic      [BANK_W-1:0] array_wr_bank,
    output logic      [ROW_W-1:0]  array_wr_row,
    output logic      [COL_W-1:0]  array_wr_col,
    output logic      [DATA_W-1:0] array_wr_data,
    output logic                   write_buffer_ready
);
    function automatic logic bl_ok(input logic [2:0] b);
        bl_ok = (b <= BL_8) || (b == BL_FULL); // R16
    endfunction
    function automatic logic [2:0] cmd_of(input logic cs, input logic r, input logic c, input logic w);
        cmd_of = cs ? CMD_NOP : {r, c, w};
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    // State
    sfb_state_e        state_reg;
    sfb_state_e        state_next;
    logic [INIT_W-1:0] init_cnt_reg;
    logic [MODE_W-1:0] mode_reg;
    logic [MODE_W-1:0] mode_next;
    logic [MODE_W-1:0] nv_mode_reg;
    logic [ROW_W-1:0]  row_reg [BANKS];
    logic [BANKS-1:0]  act_reg;
    logic [BANK_W-1:0] bank_reg;
    logic [ROW_W-1:0]  arow_reg;
    logic              is_write_reg;
    logic              rd_vld_reg;
    logic [DATA_W-1:0] wdata_reg;
    logic [DATA_W-1:0] p1_reg;
    logic [DATA_W-1:0] p2_reg;
    logic              d1_reg;
    logic              d2_reg;
    logic [DATA_W-1:0] dq_out_reg;
    logic              dq_oe_reg;
    logic              ready_reg;
    logic              awv_reg;
    logic [WORD_W-1:0] aw_reg;
    logic              wbuf_ready_reg;
    logic [COL_W-1:0]  gen_col;
    logic              gen_vld;
    logic              gen_vld_next;
    logic              fifo_in_ready;
    logic              fifo_out_valid;
    logic [WORD_W-1:0] fifo_out_data;
    ////////////////////////////////////////////////////////////////////////////
    // Command decode
    wire [2:0]        cmd      = cmd_of(cs_b, ras_b, cas_b, we_b); // R1
    wire [BANK_W-1:0] bank_in  = {bank_select_bit_high, bank_select_bit_low};
    wire [ROW_W-1:0]  row_in   = addr & (wide_config ? ROW_MASK_WIDE : ROW_MASK_NARROW); // R2
    wire [DATA_W-1:0] dmask    = wide_config ? DATA_MASK_WIDE : DATA_MASK_NARROW;
    wire              standby  = state_reg == ST_STANDBY && power_down_init_pin; // R7 R10
    wire              act_go   = standby && cmd == CMD_ACTIVE;
    wire              rd_cmd   = standby && cmd == CMD_READ;
    wire              wr_cmd   = standby && cmd == CMD_WRITE;
    wire              bst_go   = standby && cmd == CMD_BST;
    wire              aterm_go = standby && cmd == CMD_ACT_TERM;
    wire              lmr_go   = standby && cmd == CMD_LOAD_MODE;
    wire              lcr_go   = standby && cmd == CMD_LOAD_CMD; // R6
    wire              init_sw  = lcr_go && addr[COL_W-1:0] == CODE_INIT; // R8
    wire              store_go = lcr_go && addr[COL_W-1:0] == CODE_STORE_MODE; // R12
    wire              init_start = state_next == ST_INIT && state_reg != ST_INIT;
    wire              init_done  = state_reg == ST_INIT && init_cnt_reg == '0;
    ////////////////////////////////////////////////////////////////////////////
    // Configuration fields
    wire [2:0]        bl       = mode_reg[BL_MSB:BL_LSB]; // R14
    wire [2:0]        cl       = mode_reg[CL_MSB:CL_LSB];
    wire              normal   = mode_reg[OM_MSB:OM_LSB] == OM_NORMAL; // R25
    wire              cl_ok    = cl == CL_1 || cl == CL_2 || cl == CL_3;
    wire              full_rd  = bl == BL_FULL;
    wire              path_ok  = normal && act_reg[bank_in] && bl_ok(bl); // R3
    wire              rd_go    = rd_cmd && path_ok && cl_ok;
    wire              wr_go    = wr_cmd && path_ok;
    wire [LEN_W-1:0]  rd_len   = full_rd ? LEN_1 : bl[LEN_W-1:0];
    wire [LEN_W-1:0]  wr_len   = mode_reg[WB_BIT] ? LEN_1 : (full_rd ? LEN_8 : bl[LEN_W-1:0]); // R26
    wire              gen_load = rd_go || wr_go;
    wire [LEN_W-1:0]  gen_len  = rd_go ? rd_len : wr_len;
    wire              gen_full = rd_go && full_rd; // R16
    wire              gen_ilv  = mode_reg[BT_BIT] && !gen_full; // R24
    wire              gen_stop = bst_go || !power_down_init_pin; // R18
    wire              rd_next  = gen_vld_next && (rd_go || (!wr_go && !is_write_reg));
    wire              wpush    = gen_vld && is_write_reg;
    wire [WORD_W-1:0] wword    = {bank_reg, arow_reg, gen_col, wdata_reg};
    wire              aw_load  = !awv_reg || array_wr_ready;
    ////////////////////////////////////////////////////////////////////////////
    // Read latency select
    wire [DATA_W-1:0] dq_sel   = cl == CL_1 ? array_rd_data : (cl == CL_2 ? p1_reg : p2_reg); // R23
    wire              vld_sel  = cl == CL_1 ? rd_vld_reg : (cl == CL_2 ? d1_reg : d2_reg);
    wire              oe_sel   = cl == CL_1 ? rd_next : (cl == CL_2 ? rd_vld_reg : d1_reg);
    ////////////////////////////////////////////////////////////////////////////
    // Initialisation sequencing
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_POWER_DOWN: if (power_down_init_pin) state_next = ST_INIT; // R7
            ST_INIT:       if (init_done) state_next = ST_STANDBY; // R10
            ST_STANDBY:    if (init_sw) state_next = ST_INIT; // R8
            default:       state_next = ST_POWER_DOWN;
        endcase
        if (!power_down_init_pin) begin
            state_next = ST_POWER_DOWN;
        end
    end
    assign mode_next = init_start ? nv_mode_reg : (lmr_go ? addr : mode_reg); // R11 R13
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            state_reg    <= ST_POWER_DOWN;
            init_cnt_reg <= '0;
            ready_reg    <= 1'b0;
        end else begin
            state_reg <= state_next;
            ready_reg <= state_next == ST_STANDBY; // R9
            if (init_start) begin
                init_cnt_reg <= INIT_W'(INIT_CYCLES - 1); // R7 R8
            end else if (state_reg == ST_INIT && init_cnt_reg != '0) begin
                init_cnt_reg <= init_cnt_reg - INIT_W'(1);
            end
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            mode_reg    <= NV_MODE_RESET;
            nv_mode_reg <= NV_MODE_RESET;
        end else begin
            mode_reg <= mode_next;
            if (store_go) begin
                nv_mode_reg <= mode_reg; // R12
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Bank rows
    for (genvar b = 0; b < BANKS; b++) begin : g_bank
        always_ff @(posedge ref_clk) begin
            if (!rst_b || !power_down_init_pin) begin
                act_reg[b] <= 1'b0;
                row_reg[b] <= '0;
            end else if (act_go && bank_in == BANK_W'(b)) begin
                act_reg[b] <= 1'b1;
                row_reg[b] <= row_in; // R4
            end else if (aterm_go && bank_in == BANK_W'(b)) begin
                act_reg[b] <= 1'b0;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Burst control
    sfb_burst_addr u_burst (
        .ref_clk    (ref_clk),
        .rst_b      (rst_b),
        .load       (gen_load),
        .stop       (gen_stop),
        .start_col  (addr[COL_W-1:0]), // R5
        .len_log    (gen_len),
        .full_page  (gen_full),
        .interleave (gen_ilv),
        .col        (gen_col),
        .vld        (gen_vld),
        .vld_next   (gen_vld_next)
    );
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            bank_reg     <= '0;
            arow_reg     <= '0;
            is_write_reg <= 1'b0;
            rd_vld_reg   <= 1'b0;
        end else begin
            rd_vld_reg <= rd_next;
            if (gen_load) begin
                bank_reg     <= bank_in;
                arow_reg     <= row_reg[bank_in];
                is_write_reg <= wr_go;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Read data pipeline
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            p1_reg     <= '0;
            p2_reg     <= '0;
            d1_reg     <= 1'b0;
            d2_reg     <= 1'b0;
            dq_out_reg <= '0;
            dq_oe_reg  <= 1'b0;
        end else begin
            p1_reg     <= array_rd_data;
            p2_reg     <= p1_reg;
            d1_reg     <= rd_vld_reg;
            d2_reg     <= d1_reg;
            dq_oe_reg  <= oe_sel || vld_sel; // R23
            dq_out_reg <= vld_sel ? (dq_sel & dmask) : '0;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Write data path
    sfb_fifo #(
        .W     (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_wbuf (
        .ref_clk   (ref_clk),
        .rst_b     (rst_b),
        .in_valid  (wpush),
        .in_ready  (fifo_in_ready),
        .in_data   (wword),
        .out_valid (fifo_out_valid),
        .out_ready (aw_load),
        .out_data  (fifo_out_data)
    );
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            wdata_reg      <= '0;
            awv_reg        <= 1'b0;
            aw_reg         <= '0;
            wbuf_ready_reg <= 1'b0;
        end else begin
            wdata_reg      <= dq_in & dmask;
            wbuf_ready_reg <= fifo_in_ready;
            if (aw_load) begin
                awv_reg <= fifo_out_valid;
                aw_reg  <= fifo_out_data;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign dq_out             = dq_out_reg;
    assign dq_oe              = dq_oe_reg;
    assign status_ready_bit   = ready_reg;
    assign array_rd_en        = rd_vld_reg;
    assign array_bank         = bank_reg;
    assign array_row          = arow_reg;
    assign array_col          = gen_col;
    assign array_wr_valid     = awv_reg;
    assign array_wr_bank      = aw_reg[WORD_W-1 -: BANK_W];
    assign array_wr_row       = aw_reg[COL_W+DATA_W +: ROW_W];
    assign array_wr_col       = aw_reg[DATA_W +: COL_W];
    assign array_wr_data      = aw_reg[DATA_W-1:0];
    assign write_buffer_ready = wbuf_ready_reg;
    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    hw_init_a: // R7
        assert property (power_down_init_pin && state_reg == ST_POWER_DOWN |=> state_reg == ST_INIT)
        else $error("pin rise did not start init");
    ready_rise_a: // R9
        assert property ($rose(status_ready_bit) |-> $past(init_done))
        else $error("ready raised outside init end");
    standby_ready_a: // R10
        assert property (state_reg == ST_STANDBY |-> status_ready_bit)
        else $error("standby without ready bit");
    nv_restore_a: // R11
        assert property (init_start |=> mode_reg == $past(nv_mode_reg))
        else $error("init did not restore stored mode");
    nv_store_a: // R12
        assert property (store_go |=> nv_mode_reg == $past(mode_reg))
        else $error("store did not copy configuration");
    mode_hold_a: // R13
        assert property (mode_reg != $past(mode_reg) |-> $past(lmr_go) || $past(init_start))
        else $error("configuration changed without load");
    row_take_a: // R4
        assert property (act_go |=> act_reg[$past(bank_in)] && row_reg[$past(bank_in)] == $past(row_in))
        else $error("activate did not capture row");
    col_take_a: // R5
        assert property (rd_go |=> array_rd_en && array_col == $past(addr[COL_W-1:0]))
        else $error("read did not start at given column");
    cas_two_a: // R23
        assert property (rd_go && cl == CL_2 |-> ##2 dq_oe ##1 dq_oe)
        else $error("latency two drive timing wrong");
    single_write_a: // R26
        assert property (wr_go && mode_reg[WB_BIT] |=> gen_vld ##1 (!gen_vld || $past(gen_load)))
        else $error("write burst not single location");
endmodule

// file: sfb_array_model.sv
// Array model behind the front end, combinational read, stalling writes
module sfb_array_model
    import sfb_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              rd_en,
    input  wire logic [BANK_W-1:0] bank,
    input  wire logic [ROW_W-1:0]  row,
    input  wire logic [COL_W-1:0]  col,
    output logic      [DATA_W-1:0] rd_data,
    output logic                   wr_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] tick = 4'h0;
    always @(posedge ref_clk) tick <= tick + 4'h1;
    // Data names its own address; off-beat it changes every cycle
    assign rd_data  = rd_en ? {6'h0, bank, row, col, 4'h0} : {8{tick}};
    assign wr_ready = tick[1];
endmodule

// file: test_sfb_ctrl.sv
// Testbench for the command front end
module test_sfb_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    import sfb_pkg::*;
    logic              ref_clk = 1'b0;
    logic              rst_b   = 1'b0;
    logic              cs_b    = 1'b1;
    logic [2:0]        c3      = CMD_NOP;
    logic [1:0]        bk      = 2'h0;
    logic [ADDR_W-1:0] addr    = 12'h000;
    logic              pin     = 1'b0;
    logic              wide    = 1'b1;
    logic [DATA_W-1:0] dq_in   = 32'h0;
    logic [DATA_W-1:0] dq_out, rd_data, w_data;
    logic              dq_oe, rdy, rd_en, wr_ready, wv, wbr;
    logic [BANK_W-1:0] a_bank, w_bank;
    logic [ROW_W-1:0]  a_row, w_row;
    logic [COL_W-1:0]  a_col, w_col;
    int                n_errors    = 0;
    int                checks_done = 0;
    always #10 ref_clk = ~ref_clk;
    sfb_ctrl #(.INIT_CYCLES(8)) i_sfb_ctrl (.ref_clk(ref_clk), .rst_b(rst_b), .power_down_init_pin(pin),
        .cs_b(cs_b), .ras_b(c3[2]), .cas_b(c3[1]), .we_b(c3[0]), .bank_select_bit_low(bk[0]),
        .bank_select_bit_high(bk[1]), .addr(addr), .wide_config(wide), .dq_in(dq_in), .dq_out(dq_out),
        .dq_oe(dq_oe), .status_ready_bit(rdy), .array_rd_en(rd_en), .array_bank(a_bank), .array_row(a_row),
        .array_col(a_col), .array_rd_data(rd_data), .array_wr_valid(wv), .array_wr_ready(wr_ready),
        .array_wr_bank(w_bank), .array_wr_row(w_row), .array_wr_col(w_col), .array_wr_data(w_data),
        .write_buffer_ready(wbr));
    sfb_array_model i_sfb_array_model (.ref_clk(ref_clk), .rd_en(rd_en), .bank(a_bank), .row(a_row),
        .col(a_col), .rd_data(rd_data), .wr_ready(wr_ready));
    ////////////////////////////////////////////////////////////////////////////
    task check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: %h expected %h", $time, seen, exp);
        end
    endtask
    task test_done;
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task cmd(input logic [2:0] c, input logic [1:0] b, input logic [ADDR_W-1:0] a);
        @(negedge ref_clk);
        cs_b = 1'b0;
        c3   = c;
        bk   = b;
        addr = a;
        @(negedge ref_clk);
        cs_b = 1'b1;
    endtask
    task wait_ready;
        for (int i = 0; i < 40 && rdy !== 1'b1; i++) @(negedge ref_clk);
        check(rdy, 1);
    endtask
    // Load if ld is set, open a row, read a burst and compare its first n beats, then close
    task rd(input logic ld, input logic [11:0] md, input logic [7:0] st, input logic [7:0] m, input int n);
        logic [7:0] col;
        logic [11:0] row;
        row = wide ? 12'h1ab : 12'h9ab;
        if (ld) cmd(CMD_LOAD_MODE, 2'h0, md);
        cmd(CMD_ACTIVE, 2'h1, 12'h9ab);
        cmd(CMD_READ, 2'h1, {4'h0, st});
        check(a_row, row);
        repeat (md[6:4]) @(negedge ref_clk);
        for (int i = 0; i < n; i++) begin
            col = md[3] ? ((st & ~m) | ((st ^ 8'(i)) & m)) : ((st & ~m) | ((st + 8'(i)) & m));
            check(dq_oe, 1);
            check(dq_out, {6'h0, 2'h1, row, col, 4'h0} & (wide ? 32'hffffffff : 32'h0000ffff));
            @(negedge ref_clk);
        end
        cmd(CMD_BST, 2'h0, 12'h000);
        cmd(CMD_ACT_TERM, 2'h1, 12'h000);
        check(dq_oe, 0);
    endtask
    // Wait for one write handshake on the array side and compare it
    task wr_seen(input logic [7:0] c, input logic [31:0] d);
        for (int i = 0; i < 20 && !(wv === 1'b1 && wr_ready === 1'b1); i++) @(negedge ref_clk);
        check(wv && wr_ready, 1);
        check({w_bank, w_row, w_col}, {2'h2, 12'h123, c});
        check(w_data, d);
        @(negedge ref_clk);
    endtask
    // Load, open a row, write a burst of up to two beats, then close
    task wr(input logic [11:0] md, input logic [7:0] st, input logic [7:0] c1);
        cmd(CMD_LOAD_MODE, 2'h0, md);
        cmd(CMD_ACTIVE, 2'h2, 12'h123);
        dq_in = 32'h5a5a0000;
        cmd(CMD_WRITE, 2'h2, {4'h0, st});
        dq_in = 32'h5a5a0001;
        wr_seen(st, 32'h5a5a0000);
        if (!md[9]) wr_seen(c1, 32'h5a5a0001);
        check(wv, 0);
        check(wbr, 1);
        cmd(CMD_ACT_TERM, 2'h2, 12'h000);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(negedge ref_clk);
        rst_b = 1'b1;
        @(negedge ref_clk);
        check(rdy, 0);
        pin = 1'b1;
        wait_ready();
        rd(1, 12'h022, 8'h01, 8'h03, 4);
        rd(1, 12'h03b, 8'h2d, 8'h07, 8);
        wide = 1'b0;
        rd(1, 12'h010, 8'h33, 8'h00, 1);
        wide = 1'b1;
        rd(1, 12'h027, 8'hfe, 8'hff, 3);
        wr(12'h021, 8'h05, 8'h04);
        wr(12'h221, 8'h07, 8'h00);
        cmd(CMD_LOAD_MODE, 2'h0, 12'h021);
        cmd(CMD_LOAD_CMD, 2'h0, {4'h0, CODE_STORE_MODE});
        cmd(CMD_LOAD_MODE, 2'h0, 12'h033);
        cmd(CMD_LOAD_CMD, 2'h0, {4'h0, CODE_INIT});
        @(negedge ref_clk);
        check(rdy, 0);
        wait_ready();
        rd(0, 12'h021, 8'h03, 8'h01, 2);
        test_done();
    end
    initial begin
        repeat (3000) @(posedge ref_clk);
        n_errors++;
        test_done();
    end
endmodule
